// ### core/pdcsm_top.sv
/*
 * pdcsm_top: clock generation control. APB register slave, system clock
 * source switch, prescaler enables, PLL configuration guard, two DFLLs and
 * the PLL / external clock failure monitor.
 * Assumes all inputs are synchronous to CLK; oscillator and reference
 * activity arrive as one-cycle tick pulses, stability as levels.
 */
`timescale 1ns/1ps
`default_nettype none

module pdcsm_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // oscillator and reference status
  input wire logic [3:0] OSC_STABLE,
  input wire logic PLL_LOCK,
  input wire logic EXTERNAL_OSC_SOURCE_FAIL,
  input wire logic [3:0] REF_TICK,
  input wire logic [1:0] OSC_TICK,
  input wire logic SLEEP_OSC_STOP,
  // oscillator and pll control
  output logic [4:0] OSC_EN,
  output logic [4:0] PLL_FACTOR,
  output logic [1:0] PLL_SRC,
  output logic PLL_READY,
  output logic [7:0] CAL_2M,
  output logic [7:0] CAL_32M,
  // system clock and prescaler
  output logic [2:0] SYS_SEL,
  output logic SWITCH_BUSY,
  output logic PER4_EN,
  output logic PER2_EN,
  output logic CPU_EN,
  output logic NMI
);
  // ********************
  // decode helpers
  // ********************
  function automatic logic [4:0] src_bit(input logic [2:0] sel);
    src_bit = 5'h00;
    if (sel <= pdcsm_pkg::SEL_PLL) begin
      src_bit[sel] = 1'b1;
    end
  endfunction

  function automatic logic psc_a_ok(input logic [4:0] code);
    psc_a_ok = (code == 5'h00) || (code[0] && code <= pdcsm_pkg::PSC_A_MAX);
  endfunction

  logic [4:0] osc_en;
  logic [4:0] pll_mult_factor;
  logic [1:0] pll_src;
  logic pll_ready;
  logic pll_seen_lock;
  logic [3:0] dfll_ref;
  logic [1:0] dfll_en;
  logic [7:0] cal [2];
  logic [15:0] comp_32m;
  logic [1:0] fmon_en;
  logic [1:0] fail_flag;
  logic [2:0] prot_cnt;
  logic [2:0] sys_sel;
  logic [2:0] old_sel;
  logic [2:0] tgt_sel;
  pdcsm_pkg::pdcsm_sw_t sw_state;
  logic [1:0] sw_cnt;
  logic [6:0] psc_req;
  logic [6:0] psc_act;
  logic [8:0] cnt_a;
  logic [1:0] cnt_b;
  logic cnt_c;

  // ********************
  // apb access decode
  // ********************
  logic [3:0] idx;
  logic wr;
  logic prot_ok;
  logic pll_ref_ok;
  logic [4:0] keep_on;
  logic fail_x;
  logic fail_p;
  logic fail_sys;
  assign idx = PADDR[5:2];
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  assign prot_ok = prot_cnt != 3'h0;

  always_comb begin
    unique case (pll_src)
      2'h0: pll_ref_ok = OSC_STABLE[0];
      2'h1: pll_ref_ok = OSC_STABLE[1];
      default: pll_ref_ok = OSC_STABLE[3];
    endcase
  end

  // oscillators that must stay enabled
  always_comb begin
    keep_on = src_bit(sys_sel);
    if (sw_state != pdcsm_pkg::SW_IDLE) begin
      keep_on = keep_on | src_bit(old_sel) | src_bit(tgt_sel);
    end
    if (osc_en[pdcsm_pkg::OSC_PLL_BIT]) begin
      unique case (pll_src)
        2'h0: keep_on[0] = 1'b1;
        2'h1: keep_on[1] = 1'b1;
        default: keep_on[pdcsm_pkg::OSC_EXTERNAL_OSC_SOURCE_BIT] = 1'b1;
      endcase
    end
  end

  // failure detection, paused while the sources are stopped in sleep
  assign fail_x = fmon_en[0] && osc_en[pdcsm_pkg::OSC_EXTERNAL_OSC_SOURCE_BIT] && EXTERNAL_OSC_SOURCE_FAIL && !SLEEP_OSC_STOP;
  assign fail_p = fmon_en[1] && pll_seen_lock && !PLL_LOCK && !SLEEP_OSC_STOP;
  assign fail_sys = (fail_x && sys_sel == pdcsm_pkg::SEL_EXTERNAL_OSC_SOURCE) || (fail_p && sys_sel == pdcsm_pkg::SEL_PLL);

  // ********************
  // apb handshake: no wait state; ready and read data are registered from the setup cycle
  // ********************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= PSEL && !PENABLE && !PREADY;
      PSLVERR <= PSEL && !PENABLE && !PREADY && idx > pdcsm_pkg::IDX_PROTECT;
      PRDATA <= 32'h0000_0000;
      if (PSEL && !PENABLE && !PWRITE) begin
        unique case (idx)
          pdcsm_pkg::IDX_SYS_SEL: PRDATA[2:0] <= sys_sel;
          pdcsm_pkg::IDX_CLK_DIV: PRDATA[6:0] <= psc_req;
          pdcsm_pkg::IDX_OSC_CTRL: PRDATA[4:0] <= osc_en;
          pdcsm_pkg::IDX_PLL_CFG: PRDATA[9:0] <= {pll_src, 3'h0, pll_mult_factor};
          pdcsm_pkg::IDX_DFLL_REF: PRDATA[3:0] <= dfll_ref;
          pdcsm_pkg::IDX_DFLL_CTRL: PRDATA[1:0] <= dfll_en;
          pdcsm_pkg::IDX_CAL_2M: PRDATA[7:0] <= cal[0];
          pdcsm_pkg::IDX_CAL_32M: PRDATA[7:0] <= cal[1];
          pdcsm_pkg::IDX_COMP_32M: PRDATA[15:0] <= comp_32m;
          pdcsm_pkg::IDX_FAIL_MON: PRDATA[3:0] <= {fail_flag, fmon_en};
          pdcsm_pkg::IDX_STATUS: PRDATA[7:0] <= {prot_ok, sw_state != pdcsm_pkg::SW_IDLE, pll_ready, 1'b0, OSC_STABLE};
          default: PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ********************
  // timed-write protection window
  // ********************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prot_cnt <= 3'h0;
    end else if (wr && idx == pdcsm_pkg::IDX_PROTECT && PWDATA[7:0] == pdcsm_pkg::PROT_KEY) begin
      prot_cnt <= pdcsm_pkg::PROT_WIN;
    end else if (prot_ok) begin
      prot_cnt <= prot_cnt - 3'h1;
    end
  end

  // ********************
  // oscillator enables
  // ********************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      osc_en <= pdcsm_pkg::OSC_EN_RST;
    end else if (fail_sys) begin
      osc_en <= pdcsm_pkg::OSC_EN_RST;
    end else begin
      if (wr && idx == pdcsm_pkg::IDX_OSC_CTRL) begin
        osc_en <= PWDATA[4:0] | keep_on;
      end
      if (fail_x) begin
        osc_en[pdcsm_pkg::OSC_EXTERNAL_OSC_SOURCE_BIT] <= 1'b0;
      end
      if (fail_p) begin
        osc_en[pdcsm_pkg::OSC_PLL_BIT] <= 1'b0;
      end
    end
  end

  // ********************
  // pll configuration and readiness
  // ********************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pll_mult_factor <= pdcsm_pkg::PLL_MULT_FACTOR_RST;
      pll_src <= 2'h0;
    end else if (wr && idx == pdcsm_pkg::IDX_PLL_CFG && !osc_en[pdcsm_pkg::OSC_PLL_BIT]) begin
      if (PWDATA[4:0] != 5'h00) begin
        pll_mult_factor <= PWDATA[4:0];
      end
      pll_src <= PWDATA[pdcsm_pkg::PLL_SRC_LSB +: 2];
    end
  end

  // loss of lock only counts once the loop had locked
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pll_ready <= 1'b0;
      pll_seen_lock <= 1'b0;
    end else begin
      pll_ready <= osc_en[pdcsm_pkg::OSC_PLL_BIT] && PLL_LOCK && pll_ref_ok;
      if (!osc_en[pdcsm_pkg::OSC_PLL_BIT] || fail_p) begin
        pll_seen_lock <= 1'b0;
      end else if (pll_ready) begin
        pll_seen_lock <= 1'b1;
      end
    end
  end

  // ********************
  // failure monitor enables and flags
  // ********************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fmon_en <= 2'h0;
      fail_flag <= 2'h0;
      NMI <= 1'b0;
    end else begin
      NMI <= fail_sys;
      if (wr && idx == pdcsm_pkg::IDX_FAIL_MON && prot_ok) begin
        fmon_en <= fmon_en | PWDATA[1:0];
        fail_flag <= (fail_flag & ~PWDATA[pdcsm_pkg::FAIL_FLAG_LSB +: 2]) | {fail_p, fail_x};
      end else begin
        fail_flag <= fail_flag | {fail_p, fail_x};
      end
    end
  end

  // ********************
  // system clock source switch
  // ********************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sys_sel <= pdcsm_pkg::SEL_RC2M;
      old_sel <= pdcsm_pkg::SEL_RC2M;
      tgt_sel <= pdcsm_pkg::SEL_RC2M;
      sw_state <= pdcsm_pkg::SW_IDLE;
      sw_cnt <= 2'h0;
      SWITCH_BUSY <= 1'b0;
    end else if (fail_sys) begin
      sys_sel <= pdcsm_pkg::SEL_RC2M;
      sw_state <= pdcsm_pkg::SW_IDLE;
      sw_cnt <= 2'h0;
      SWITCH_BUSY <= 1'b0;
    end else begin
      unique case (sw_state)
        pdcsm_pkg::SW_IDLE: begin
          if (wr && idx == pdcsm_pkg::IDX_SYS_SEL && prot_ok
              && PWDATA[2:0] <= pdcsm_pkg::SEL_PLL && PWDATA[2:0] != sys_sel
              && (PWDATA[2:0] == pdcsm_pkg::SEL_PLL ? pll_ready : OSC_STABLE[PWDATA[1:0]])) begin
            tgt_sel <= PWDATA[2:0];
            old_sel <= sys_sel;
            sw_cnt <= 2'h0;
            sw_state <= pdcsm_pkg::SW_OLD;
            SWITCH_BUSY <= 1'b1;
          end
        end
        pdcsm_pkg::SW_OLD: begin
          sw_cnt <= sw_cnt + 2'h1;
          if (sw_cnt == pdcsm_pkg::SW_CYC_M1) begin
            sys_sel <= tgt_sel;
            sw_cnt <= 2'h0;
            sw_state <= pdcsm_pkg::SW_NEW;
          end
        end
        pdcsm_pkg::SW_NEW: begin
          sw_cnt <= sw_cnt + 2'h1;
          if (sw_cnt == pdcsm_pkg::SW_CYC_M1) begin
            sw_cnt <= 2'h0;
            sw_state <= pdcsm_pkg::SW_IDLE;
            SWITCH_BUSY <= 1'b0;
          end
        end
        default: begin
          sw_state <= pdcsm_pkg::SW_IDLE;
          SWITCH_BUSY <= 1'b0;
        end
      endcase
    end
  end

  // ********************
  // prescalers
  // ********************
  logic [3:0] a_shift;
  logic [8:0] a_m1;
  logic [1:0] b_m1;
  logic a_hit;
  logic b_hit;
  logic c_hit;
  assign a_shift = (psc_act[6:2] == 5'h00) ? 4'h0 : 4'((psc_act[6:2] + 5'h01) >> 1);
  assign a_m1 = 9'((10'h001 << a_shift) - 10'h001);
  assign b_m1 = (psc_act[1:0] == 2'h2) ? 2'h3 : {1'b0, psc_act[1:0] == 2'h3};
  assign a_hit = cnt_a == a_m1;
  assign b_hit = a_hit && cnt_b == b_m1;
  assign c_hit = b_hit && cnt_c == psc_act[0];

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      psc_req <= 7'h00;
    end else if (wr && idx == pdcsm_pkg::IDX_CLK_DIV && prot_ok
                 && psc_a_ok(PWDATA[pdcsm_pkg::PSC_A_LSB +: 5])) begin
      psc_req <= PWDATA[6:0];
    end
  end

  // counters restart together so derived enables stay in phase
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      psc_act <= 7'h00;
      cnt_a <= 9'h000;
      cnt_b <= 2'h0;
      cnt_c <= 1'b0;
      PER4_EN <= 1'b0;
      PER2_EN <= 1'b0;
      CPU_EN <= 1'b0;
    end else begin
      PER4_EN <= a_hit;
      PER2_EN <= b_hit;
      CPU_EN <= c_hit;
      if (c_hit) begin
        psc_act <= psc_req;
        cnt_a <= 9'h000;
        cnt_b <= 2'h0;
        cnt_c <= 1'b0;
      end else if (b_hit) begin
        cnt_a <= 9'h000;
        cnt_b <= 2'h0;
        cnt_c <= ~cnt_c;
      end else if (a_hit) begin
        cnt_a <= 9'h000;
        cnt_b <= cnt_b + 2'h1;
      end else begin
        cnt_a <= cnt_a + 9'h001;
      end
    end
  end

  // ********************
  // dfll configuration
  // ********************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dfll_ref <= 4'h0;
      dfll_en <= 2'h0;
      comp_32m <= pdcsm_pkg::COMP_32M_RST;
    end else if (wr) begin
      if (idx == pdcsm_pkg::IDX_DFLL_REF) begin
        dfll_ref <= PWDATA[3:0];
      end
      if (idx == pdcsm_pkg::IDX_DFLL_CTRL) begin
        dfll_en <= PWDATA[1:0];
      end
      if (idx == pdcsm_pkg::IDX_COMP_32M) begin
        comp_32m <= PWDATA[15:0];
      end
    end
  end

  // ********************
  // dfll loops: index 0 trims 2MHz, index 1 trims 32MHz
  // ********************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_dfll
      logic [4:0] ref_div;
      logic [15:0] osc_cnt;
      logic [15:0] comp;
      logic [1:0] rsel;
      logic run;
      logic tick;
      assign rsel = dfll_ref[2 * gi +: 2];
      assign comp = (gi == 0) ? pdcsm_pkg::COMP_2M_RST : comp_32m;
      assign run = dfll_en[gi] && !SLEEP_OSC_STOP;
      assign tick = REF_TICK[rsel] && ref_div == pdcsm_pkg::DFLL_REF_DIV_M1;

      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          ref_div <= 5'h00;
          osc_cnt <= 16'h0000;
        end else if (!dfll_en[gi]) begin
          ref_div <= 5'h00;
          osc_cnt <= 16'h0000;
        end else if (run) begin
          if (REF_TICK[rsel]) begin
            ref_div <= ref_div + 5'h01;
          end
          if (tick) begin
            osc_cnt <= {15'h0000, OSC_TICK[gi]};
          end else if (OSC_TICK[gi] && osc_cnt != 16'hFFFF) begin
            osc_cnt <= osc_cnt + 16'h0001;
          end
        end
      end

      // calibration holds through sleep; software owns it while disabled
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          cal[gi] <= pdcsm_pkg::CAL_RST;
        end else if (!dfll_en[gi]) begin
          if (wr && idx == ((gi == 0) ? pdcsm_pkg::IDX_CAL_2M : pdcsm_pkg::IDX_CAL_32M)) begin
            cal[gi] <= PWDATA[7:0];
          end
        end else if (run && tick) begin
          // one spare bit so a large compare value cannot wrap the margin
          if ({1'b0, osc_cnt} > {1'b0, comp} + 17'(pdcsm_pkg::CAL_HALF_STEP) && cal[gi] != 8'h00) begin
            cal[gi] <= cal[gi] - 8'h01;
          end else if ({1'b0, osc_cnt} + 17'(pdcsm_pkg::CAL_HALF_STEP) < {1'b0, comp} && cal[gi] != 8'hFF) begin
            cal[gi] <= cal[gi] + 8'h01;
          end
        end
      end
    end
  endgenerate

  // ********************
  // outputs
  // ********************
  assign OSC_EN = osc_en;
  assign PLL_FACTOR = pll_mult_factor;
  assign PLL_SRC = pll_src;
  assign PLL_READY = pll_ready;
  assign CAL_2M = cal[0];
  assign CAL_32M = cal[1];
  assign SYS_SEL = sys_sel;
endmodule

`default_nettype wire

// ### inc/pdcsm_pkg.sv
/*
 * pdcsm_pkg: register map, field layout, reset values, codes and timing
 * counts of the clock select, PLL, DFLL and failure monitor control block.
 * Assumes a 32-bit APB with one register per aligned word.
 */
package pdcsm_pkg;
  // ********************
  // register indices; byte address is four times the index
  // ********************
  localparam logic [3:0] IDX_SYS_SEL = 4'h0;
  localparam logic [3:0] IDX_CLK_DIV = 4'h1;
  localparam logic [3:0] IDX_OSC_CTRL = 4'h2;
  localparam logic [3:0] IDX_PLL_CFG = 4'h3;
  localparam logic [3:0] IDX_DFLL_REF = 4'h4;
  localparam logic [3:0] IDX_DFLL_CTRL = 4'h5;
  localparam logic [3:0] IDX_CAL_2M = 4'h6;
  localparam logic [3:0] IDX_CAL_32M = 4'h7;
  localparam logic [3:0] IDX_COMP_32M = 4'h8;
  localparam logic [3:0] IDX_FAIL_MON = 4'h9;
  localparam logic [3:0] IDX_STATUS = 4'hA;
  localparam logic [3:0] IDX_PROTECT = 4'hB;
  // ********************
  // field positions
  // ********************
  localparam int PSC_A_LSB = 2;
  localparam int PLL_SRC_LSB = 8;
  localparam int DFLL_REF32_LSB = 2;
  localparam int FAIL_FLAG_LSB = 2;
  // ********************
  // codes and reset values
  // ********************
  localparam logic [2:0] SEL_RC2M = 3'h0;
  localparam logic [2:0] SEL_EXTERNAL_OSC_SOURCE = 3'h3;
  localparam logic [2:0] SEL_PLL = 3'h4;
  localparam logic [4:0] PSC_A_MAX = 5'h11;
  localparam logic [4:0] OSC_EN_RST = 5'h01;
  localparam int OSC_PLL_BIT = 4;
  localparam int OSC_EXTERNAL_OSC_SOURCE_BIT = 3;
  localparam logic [4:0] PLL_MULT_FACTOR_RST = 5'h01;
  localparam logic [7:0] CAL_RST = 8'h80;
  localparam logic [15:0] COMP_2M_RST = 16'h07A1;
  localparam logic [15:0] COMP_32M_RST = 16'h7A12;
  localparam logic [15:0] CAL_HALF_STEP = 16'h0008;
  localparam logic [4:0] DFLL_REF_DIV_M1 = 5'h1F;
  localparam logic [7:0] PROT_KEY = 8'hD8;
  localparam logic [2:0] PROT_WIN = 3'h4;
  localparam logic [1:0] SW_CYC_M1 = 2'h1;
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_OLD = 2'b01,
    SW_NEW = 2'b10
  } pdcsm_sw_t;
endpackage

// ### testbench/pdcsm_checker.sv
/*
 * pdcsm_checker: concurrent checks on the ports of pdcsm_top.
 * Assumes a bind onto pdcsm_top, rising CLK, RST asynchronous active high.
 */
`timescale 1ns/1ps
`default_nettype none
module pdcsm_checker (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // watched ports
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic [4:0] OSC_EN,
  input wire logic [4:0] PLL_FACTOR,
  input wire logic [1:0] PLL_SRC,
  input wire logic PLL_LOCK,
  input wire logic PLL_READY,
  input wire logic [2:0] SYS_SEL,
  input wire logic SWITCH_BUSY,
  input wire logic PER4_EN,
  input wire logic PER2_EN,
  input wire logic CPU_EN,
  input wire logic NMI
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // pll reference codes 2 and 3 share the external enable bit
  logic [2:0] ref_bit;
  assign ref_bit = PLL_SRC[1] ? 3'h3 : {1'b0, PLL_SRC};
  property p_apb_ready; PSEL && !PENABLE |=> PREADY; endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
  property p_factor; PLL_FACTOR != 5'h00; endproperty
  a_factor: assert property (p_factor) else $error("pll factor zero");
  property p_pll_cfg; OSC_EN[4] && $past(OSC_EN[4]) |-> $stable(PLL_FACTOR) && $stable(PLL_SRC); endproperty
  a_pll_cfg: assert property (p_pll_cfg) else $error("pll config changed while on");
  property p_pll_ready; PLL_READY |-> $past(OSC_EN[4] && PLL_LOCK); endproperty
  a_pll_ready: assert property (p_pll_ready) else $error("pll ready without lock");
  property p_pll_ref; OSC_EN[4] |-> OSC_EN[ref_bit]; endproperty
  a_pll_ref: assert property (p_pll_ref) else $error("pll reference off");
  property p_nmi; NMI |-> SYS_SEL == pdcsm_pkg::SEL_RC2M && OSC_EN == pdcsm_pkg::OSC_EN_RST; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi without fallback");
  property p_sel_legal; SYS_SEL <= pdcsm_pkg::SEL_PLL; endproperty
  a_sel_legal: assert property (p_sel_legal) else $error("reserved source active");
  property p_switch_len; $rose(SWITCH_BUSY) |-> SWITCH_BUSY [*4] ##1 !SWITCH_BUSY; endproperty
  a_switch_len: assert property (p_switch_len) else $error("switch length wrong");
  property p_switch_mid; $rose(SWITCH_BUSY) |-> $stable(SYS_SEL) ##1 $stable(SYS_SEL) ##1 $changed(SYS_SEL); endproperty
  a_switch_mid: assert property (p_switch_mid) else $error("switch moment wrong");
  property p_active_on; OSC_EN[SYS_SEL] == 1'b1; endproperty
  a_active_on: assert property (p_active_on) else $error("active source disabled");
  property p_presc; CPU_EN |-> PER2_EN && PER4_EN; endproperty
  a_presc: assert property (p_presc) else $error("derived clocks out of phase");
  c_switch: cover property ($rose(SWITCH_BUSY));
  c_nmi: cover property (NMI);
  c_pll: cover property (PLL_READY);
endmodule
`default_nettype wire

// ### testbench/pdcsm_tb_top.sv
/*
 * pdcsm_tb_top: self-checking bench for pdcsm_top, APB master and status stimulus.
 * Assumes pdcsm_pkg compiled first and pdcsm_checker available for the bind.
 */
`timescale 1ns/1ps
`default_nettype none
module pdcsm_tb_top;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, PLL_READY, SWITCH_BUSY, PER4_EN, PER2_EN, CPU_EN, NMI;
  logic [3:0] OSC_STABLE = 4'hF;
  logic PLL_LOCK = 1'b1;
  logic EXTERNAL_OSC_SOURCE_FAIL = 1'b0;
  logic [3:0] REF_TICK = 4'h0;
  logic [1:0] OSC_TICK = 2'h0;
  logic SLEEP_OSC_STOP = 1'b0;
  logic [4:0] OSC_EN, PLL_FACTOR;
  logic [1:0] PLL_SRC;
  logic [7:0] CAL_2M, CAL_32M;
  logic [2:0] SYS_SEL;
  logic [32:0] exp_q[$];
  int fails = 0;
  int samples_checked = 0;
  integer seed = 32'h02a5;
  pdcsm_top dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .OSC_STABLE(OSC_STABLE),
    .PLL_LOCK(PLL_LOCK), .EXTERNAL_OSC_SOURCE_FAIL(EXTERNAL_OSC_SOURCE_FAIL), .REF_TICK(REF_TICK), .OSC_TICK(OSC_TICK),
    .SLEEP_OSC_STOP(SLEEP_OSC_STOP), .OSC_EN(OSC_EN), .PLL_FACTOR(PLL_FACTOR), .PLL_SRC(PLL_SRC),
    .PLL_READY(PLL_READY), .CAL_2M(CAL_2M), .CAL_32M(CAL_32M), .SYS_SEL(SYS_SEL), .SWITCH_BUSY(SWITCH_BUSY),
    .PER4_EN(PER4_EN), .PER2_EN(PER2_EN), .CPU_EN(CPU_EN), .NMI(NMI));
  // ********************
  // clock, ticks, checking
  // ********************
  always #20 CLK = ~CLK;
  always @(posedge CLK) begin
    REF_TICK <= 4'($random(seed));
    OSC_TICK <= 2'($random(seed));
  end
  task chk(input logic [32:0] e, input logic [32:0] s, input string what);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, e, s);
    end
  endtask
  // read data stands only in the access cycle, so compare there
  always @(negedge CLK) begin
    if (PSEL && PENABLE && PREADY && !PWRITE) begin
      if (exp_q.size() > 0) chk(exp_q.pop_front(), {PSLVERR, PRDATA}, "read");
      else fails++;
    end
  end
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ********************
  // apb master
  // ********************
  task apb(input logic w, input logic [3:0] idx, input logic [31:0] d, input logic more);
    int n;
    // penable is already low from the previous transfer
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {6'h00, idx, 2'h0};
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    @(negedge CLK);
    while (PREADY !== 1'b1 && n < 20) begin
      @(negedge CLK);
      n++;
    end
    if (n == 20) begin
      fails++;
      finish_test;
    end
    @(posedge CLK);
    PENABLE <= 1'b0;
    if (!more) begin
      PSEL <= 1'b0;
      @(posedge CLK);
    end
  endtask
  task wr(input logic [3:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 1'b0);
  endtask
  task rd(input logic [3:0] idx, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, idx, 32'h0, 1'b0);
  endtask
  // key then write back to back keeps the write inside the window
  task prot(input logic [3:0] idx, input logic [31:0] d);
    apb(1'b1, pdcsm_pkg::IDX_PROTECT, {24'h0, pdcsm_pkg::PROT_KEY}, 1'b1);
    apb(1'b1, idx, d, 1'b0);
  endtask
  task settle;
    int n;
    n = 0;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    while (SWITCH_BUSY !== 1'b0 && n < 50) begin
      @(negedge CLK);
      n++;
    end
    if (n == 50) begin
      fails++;
      finish_test;
    end
    @(posedge CLK);
  endtask
  function logic pick(input int s);
    return s == 0 ? PER4_EN : (s == 1 ? PER2_EN : CPU_EN);
  endfunction
  task per(input int s, input int e);
    int n, c;
    n = 0;
    c = 0;
    @(negedge CLK);
    while (pick(s) !== 1'b1 && n < 5000) begin
      @(negedge CLK);
      n++;
    end
    do begin
      @(negedge CLK);
      c++;
    end while (pick(s) !== 1'b1 && c < 5000);
    chk(e, c, "period");
    @(posedge CLK);
  endtask
  // ********************
  // scenarios
  // ********************
  logic [3:0] ri[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8, 4'hC};
  logic [32:0] rv[8] = '{33'h0, 33'h0, 33'h01, 33'h01, 33'h80, 33'h80, 33'h7A12, 33'h1_0000_0000};
  int codes[8] = '{4, 1, 5, 3, 6, 2, 7, 0};
  logic [2:0] cur;
  logic [4:0] pa;
  logic [1:0] pbc;
  logic [31:0] r;
  int n, da, db, dc;
  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    for (int i = 0; i < 8; i++) rd(ri[i], rv[i]);
    wr(pdcsm_pkg::IDX_OSC_CTRL, 32'h1F);
    wr(pdcsm_pkg::IDX_SYS_SEL, 32'h1);
    rd(pdcsm_pkg::IDX_SYS_SEL, 33'h0);
    cur = 3'h0;
    foreach (codes[i]) begin
      if (codes[i] <= 4) cur = 3'(codes[i]);
      prot(pdcsm_pkg::IDX_SYS_SEL, codes[i]);
      settle;
      rd(pdcsm_pkg::IDX_SYS_SEL, {30'h0, cur});
    end
    OSC_STABLE <= 4'hD;
    prot(pdcsm_pkg::IDX_SYS_SEL, 32'h1);
    settle;
    rd(pdcsm_pkg::IDX_SYS_SEL, 33'h0);
    OSC_STABLE <= 4'hF;
    wr(pdcsm_pkg::IDX_PLL_CFG, 32'h105);
    rd(pdcsm_pkg::IDX_PLL_CFG, 33'h1);
    wr(pdcsm_pkg::IDX_OSC_CTRL, 32'h0F);
    r = $random(seed) & 32'h31F;
    if (r[4:0] == 5'h00) r[0] = 1'b1;
    wr(pdcsm_pkg::IDX_PLL_CFG, r);
    rd(pdcsm_pkg::IDX_PLL_CFG, {1'b0, r});
    chk({26'h0, r[9:8], r[4:0]}, {26'h0, PLL_SRC, PLL_FACTOR}, "pll pins");
    wr(pdcsm_pkg::IDX_PLL_CFG, 32'h100);
    rd(pdcsm_pkg::IDX_PLL_CFG, {23'h0, 2'h1, 3'h0, r[4:0]});
    wr(pdcsm_pkg::IDX_PLL_CFG, 32'h105);
    wr(pdcsm_pkg::IDX_OSC_CTRL, 32'h13);
    wr(pdcsm_pkg::IDX_OSC_CTRL, 32'h11);
    rd(pdcsm_pkg::IDX_OSC_CTRL, 33'h13);
    rd(pdcsm_pkg::IDX_STATUS, 33'h2F);
    wr(pdcsm_pkg::IDX_OSC_CTRL, 32'h0B);
    r = $random(seed);
    wr(pdcsm_pkg::IDX_CAL_2M, {24'h0, r[7:0]});
    rd(pdcsm_pkg::IDX_CAL_2M, {25'h0, r[7:0]});
    wr(pdcsm_pkg::IDX_COMP_32M, {16'h0, r[23:8]});
    rd(pdcsm_pkg::IDX_COMP_32M, {17'h0, r[23:8]});
    // failure of the active external source
    wr(pdcsm_pkg::IDX_OSC_CTRL, 32'h09);
    prot(pdcsm_pkg::IDX_FAIL_MON, 32'h3);
    prot(pdcsm_pkg::IDX_SYS_SEL, 32'h3);
    settle;
    EXTERNAL_OSC_SOURCE_FAIL <= 1'b1;
    n = 0;
    @(negedge CLK);
    while (NMI !== 1'b1 && n < 10) begin
      @(negedge CLK);
      n++;
    end
    chk(33'h1, {32'h0, NMI}, "nmi");
    @(posedge CLK);
    EXTERNAL_OSC_SOURCE_FAIL <= 1'b0;
    rd(pdcsm_pkg::IDX_SYS_SEL, 33'h0);
    rd(pdcsm_pkg::IDX_OSC_CTRL, 33'h01);
    rd(pdcsm_pkg::IDX_FAIL_MON, 33'h07);
    prot(pdcsm_pkg::IDX_FAIL_MON, 32'h0);
    rd(pdcsm_pkg::IDX_FAIL_MON, 33'h07);
    // failure of an idle external source
    wr(pdcsm_pkg::IDX_OSC_CTRL, 32'h09);
    EXTERNAL_OSC_SOURCE_FAIL <= 1'b1;
    n = 0;
    repeat (6) begin
      @(negedge CLK);
      if (NMI !== 1'b0) n++;
    end
    chk(33'h0, n, "nmi count");
    @(posedge CLK);
    EXTERNAL_OSC_SOURCE_FAIL <= 1'b0;
    rd(pdcsm_pkg::IDX_OSC_CTRL, 33'h01);
    rd(pdcsm_pkg::IDX_SYS_SEL, 33'h0);
    // dfll loops: 2MHz runs slow against its ideal count, 32MHz fast against zero
    wr(pdcsm_pkg::IDX_CAL_2M, 32'h40);
    wr(pdcsm_pkg::IDX_CAL_32M, 32'h40);
    wr(pdcsm_pkg::IDX_COMP_32M, 32'h0);
    wr(pdcsm_pkg::IDX_DFLL_REF, 32'hC);
    wr(pdcsm_pkg::IDX_DFLL_CTRL, 32'h3);
    repeat (400) @(posedge CLK);
    @(negedge CLK);
    chk(33'h1, {32'h0, CAL_2M > 8'h40 && CAL_32M < 8'h40}, "dfll step");
    @(posedge CLK);
    SLEEP_OSC_STOP <= 1'b1;
    wr(pdcsm_pkg::IDX_OSC_CTRL, 32'h09);
    EXTERNAL_OSC_SOURCE_FAIL <= 1'b1;
    r[15:0] = {CAL_32M, CAL_2M};
    wr(pdcsm_pkg::IDX_CAL_2M, 32'h11);
    repeat (200) @(posedge CLK);
    chk({17'h0, r[15:0]}, {17'h0, CAL_32M, CAL_2M}, "dfll hold");
    rd(pdcsm_pkg::IDX_OSC_CTRL, 33'h09);
    EXTERNAL_OSC_SOURCE_FAIL <= 1'b0;
    SLEEP_OSC_STOP <= 1'b0;
    wr(pdcsm_pkg::IDX_DFLL_CTRL, 32'h0);
    // prescaler codes, reserved ones leave the setting alone
    pa = 5'h00;
    pbc = 2'h0;
    for (int k = 0; k < 20; k++) begin
      if (k == 0 || (k[0] && k <= pdcsm_pkg::PSC_A_MAX)) begin
        pa = 5'(k);
        pbc = 2'(k);
      end
      prot(pdcsm_pkg::IDX_CLK_DIV, {25'h0, 5'(k), 2'(k)});
      rd(pdcsm_pkg::IDX_CLK_DIV, {26'h0, pa, pbc});
      da = pa == 5'h00 ? 1 : 1 << ((pa + 1) / 2);
      db = pbc == 2'h2 ? 4 : (pbc == 2'h3 ? 2 : 1);
      dc = pbc[0] ? 2 : 1;
      per(2, da * db * dc);
      per(0, da);
      per(1, da * db);
    end
    finish_test;
  end
  initial begin
    repeat (100000) @(posedge CLK);
    fails++;
    finish_test;
  end
endmodule
bind pdcsm_top pdcsm_checker u_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .OSC_EN(OSC_EN), .PLL_FACTOR(PLL_FACTOR), .PLL_SRC(PLL_SRC), .PLL_LOCK(PLL_LOCK), .PLL_READY(PLL_READY),
  .SYS_SEL(SYS_SEL), .SWITCH_BUSY(SWITCH_BUSY), .PER4_EN(PER4_EN), .PER2_EN(PER2_EN), .CPU_EN(CPU_EN),
  .NMI(NMI));
`default_nettype wire
